/* File: src/sfsr_cfg.svh */
// Constants for the serial flash status and read command block
`ifndef SFSR_CFG_SVH
`define SFSR_CFG_SVH

// ============================================================
// Opcodes
`define SFSR_OP_WRITE_ENABLE 8'h06
`define SFSR_OP_VOL_ENABLE 8'h50
`define SFSR_OP_STATUS_READ_LO 8'h05
`define SFSR_OP_STATUS_READ_HI 8'h35
`define SFSR_OP_INT_STATUS 8'h25
`define SFSR_OP_STATUS_WRITE 8'h01
`define SFSR_OP_READ 8'h03
`define SFSR_OP_FAST_READ 8'h0B
`define SFSR_OP_DUAL_READ 8'h3B

// ============================================================
// Status word layout
`define SFSR_BIT_WIP 0
`define SFSR_BIT_WEL 1
`define SFSR_BIT_BP_LO 2
`define SFSR_BIT_BP_HI 6
`define SFSR_BIT_STATUS_PROTECT_LOW 7
`define SFSR_BIT_STATUS_PROTECT_HIGH 8
`define SFSR_KEEP_MASK 16'h8403
`define SFSR_STATUS_RESET 16'h0000

// ============================================================
// Frame and timing counts
`define SFSR_ADDR_BITS 5'h18
`define SFSR_DUMMY_BITS 5'h08
`define SFSR_WR_SAT 5'h11
`define SFSR_PIN_RESET 4'h9
`define SFSR_CLK_MHZ 50
`define SFSR_TW_US 10000
`define SFSR_TW_CYCLES (`SFSR_TW_US * `SFSR_CLK_MHZ)

`endif

/* File: src/sfsr_pkg.sv */
// Types for the serial flash status and read command block
package sfsr_pkg;
   typedef enum logic [3:0] {
      SFSR_IDLE,
      SFSR_OPCODE,
      SFSR_ADDR,
      SFSR_DUMMY,
      SFSR_DATA,
      SFSR_STATUS,
      SFSR_INT,
      SFSR_WRDATA,
      SFSR_IGNORE
   } sfsr_state_t;
endpackage : sfsr_pkg

/* File: src/sfsr_pin_sync.sv */
// Two-flop synchronisers for the pins entering the core clock domain
`timescale 1ns/1ps
module sfsr_pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   generate
      if (WIDTH < 1) begin : g_bad
         $error("sfsr_pin_sync needs at least one bit");
      end
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         logic meta;
         // First stage feeds only the second stage
         always_ff @(posedge core_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               meta <= RESET_VAL[i];
               sync_out[i] <= RESET_VAL[i];
            end else begin
               meta <= async_in[i];
               sync_out[i] <= meta;
            end
         end
      end
   endgenerate
endmodule : sfsr_pin_sync

/* File: src/sfsr_core.sv */
// Serial flash command engine: status read/write, interrupt status, array reads
`timescale 1ns/1ps
`include "sfsr_cfg.svh"

// Contract
// RULE1 - Host sends volatile enable then status write directly to change only volatile copy.
// RULE2 - Volatile enable leaves write enable latch alone, arms only next status write.
// RULE3 - Non-volatile status is copied into volatile status after reset; volatile governs.
// RULE4 - Status read sends low byte for one opcode, high byte for other.
// RULE5 - Status reads always accepted, even busy; shifting continues while selected.
// RULE6 - Continuous status read repeats selected byte, refreshed, every eight clocks.
// RULE7 - Host should poll write in progress before new commands during busy cycles.
// RULE8 - Interrupt status drives write in progress on output, updated without clocks.
// RULE9 - Interrupt status output may fall on completion, never rises during mode; code copies write in progress, so it rises if array_busy_in rises.
// RULE10 - Deselect ends interrupt status anytime and floats the output.
// RULE11 - Status write needs write enable latch set by earlier write enable.
// RULE12 - Write enable sets latch when select rises after opcode byte.
// RULE13 - Status write never changes bits 15, 10, 1 and 0.
// RULE14 - Status write runs only after exactly 8 or 16 data bits.
// RULE15 - Deselect starts timed write; in-progress high throughout, then both flags clear.
// RULE16 - Status write updates protect bits, refused under hardware protection.
// RULE17 - Normal read takes 24 address bits on rising edges, data out falling.
// RULE18 - Read address increments per byte and wraps to zero.
// RULE19 - Deselect ends array read at any point, even mid byte.
// RULE20 - Array reads during busy cycles are ignored without disturbing them.
// RULE21 - Fast read expects address plus one dummy byte before data.
// RULE22 - Dual read outputs two bits per clock on both lines.
// RULE23 - Dual read has eight dummy clocks after address; input ignored.
// RULE24 - Dual data: line 1 odd bits, line 0 even bits, MSB pair first.
// RULE25 - Host releases data line 0 before first dual data falling edge.
module sfsr_core #(
   parameter int TW_CYCLES = `SFSR_TW_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic spi_csn_in,
   input wire logic spi_sclk_in,
   input wire logic wp_n_in,
   input wire logic data_line_0_in,
   output logic data_line_0_out,
   output logic data_line_0_oe_out,
   input wire logic data_line_1_in,
   output logic data_line_1_out,
   output logic data_line_1_oe_out,
   input wire logic [15:0] nv_status_in,
   input wire logic array_busy_in,
   input wire logic [7:0] mem_data_in,
   output logic [23:0] mem_addr_out,
   output logic [15:0] status_out,
   output logic nv_write_out,
   output logic [15:0] nv_data_out
);
   import sfsr_pkg::*;

   generate
      if (TW_CYCLES < 2) begin : g_bad_tw
         $error("TW_CYCLES must be at least 2");
      end
   endgenerate

   // ============================================================
   // Pin synchronisers and edge detection
   logic [3:0] pins_s;
   logic csn_s, sclk_s, din_s, wpn_s;
   logic csn_d, sclk_d;

   sfsr_pin_sync #(.WIDTH(4), .RESET_VAL(`SFSR_PIN_RESET)) u_sync (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .async_in({wp_n_in, data_line_0_in, spi_sclk_in, spi_csn_in}),
      .sync_out(pins_s)
   );

   assign {wpn_s, din_s, sclk_s, csn_s} = pins_s;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         csn_d <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         csn_d <= csn_s;
         sclk_d <= sclk_s;
      end
   end

   wire selected = ~csn_s;
   wire sclk_rise = selected & sclk_s & ~sclk_d;
   wire sclk_fall = selected & ~sclk_s & sclk_d;
   wire cs_rise = csn_s & ~csn_d;

   // ============================================================
   // Command state
   sfsr_state_t state;
   logic [4:0] bit_cnt;
   logic [7:0] rx;
   logic [7:0] cmd;
   logic [23:0] addr;
   logic [15:0] wr_data;
   logic [4:0] wr_cnt;
   logic [7:0] tx_sh;
   logic [2:0] tx_cnt;
   logic [15:2] vol_bits;
   logic write_enable_latch, write_in_progress_flag, vol_arm, loaded, cycle_busy;
   logic [31:0] timer;

   wire [7:0] next_op = {rx[6:0], din_s};
   wire op_done = (state == SFSR_OPCODE) & sclk_rise & (bit_cnt == 5'h07);
   wire is_read = (next_op == `SFSR_OP_READ) | (next_op == `SFSR_OP_FAST_READ) |
                  (next_op == `SFSR_OP_DUAL_READ);
   wire is_dual = (cmd == `SFSR_OP_DUAL_READ);
   wire addr_done = (state == SFSR_ADDR) & sclk_rise & (bit_cnt == `SFSR_ADDR_BITS - 5'h01);
   wire dummy_done = (state == SFSR_DUMMY) & sclk_rise & (bit_cnt == `SFSR_DUMMY_BITS - 5'h01);
   wire [2:0] tx_last = is_dual ? 3'h3 : 3'h7;
   wire byte_done = (state == SFSR_DATA) & sclk_fall & (tx_cnt == tx_last);

   // Decode, address capture and input shifting
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= SFSR_IDLE;
         bit_cnt <= 5'h00;
         rx <= 8'h00;
         cmd <= 8'h00;
         addr <= 24'h000000;
         wr_data <= 16'h0000;
         wr_cnt <= 5'h00;
      end else if (!selected || !loaded) begin
         state <= SFSR_IDLE; // [RULE10] [RULE19]
         bit_cnt <= 5'h00;
      end else begin
         case (state)
            SFSR_IDLE: begin
               state <= SFSR_OPCODE;
               bit_cnt <= 5'h00;
               wr_cnt <= 5'h00;
            end
            SFSR_OPCODE: begin
               if (sclk_rise) begin
                  rx <= next_op;
                  bit_cnt <= bit_cnt + 5'h01;
               end
               if (op_done) begin
                  cmd <= next_op;
                  bit_cnt <= 5'h00;
                  if (next_op == `SFSR_OP_STATUS_READ_LO || next_op == `SFSR_OP_STATUS_READ_HI) begin
                     state <= SFSR_STATUS; // [RULE5]
                  end else if (next_op == `SFSR_OP_INT_STATUS) begin
                     state <= SFSR_INT; // [RULE8]
                  end else if (next_op == `SFSR_OP_STATUS_WRITE) begin
                     state <= SFSR_WRDATA;
                  end else if (is_read && !write_in_progress_flag) begin
                     state <= SFSR_ADDR; // [RULE17]
                  end else begin
                     state <= SFSR_IGNORE; // [RULE20]
                  end
               end
            end
            SFSR_ADDR: begin
               if (sclk_rise) begin
                  addr <= {addr[22:0], din_s}; // [RULE17]
                  bit_cnt <= bit_cnt + 5'h01;
               end
               if (addr_done) begin
                  bit_cnt <= 5'h00;
                  state <= (cmd == `SFSR_OP_READ) ? SFSR_DATA : SFSR_DUMMY;
               end
            end
            SFSR_DUMMY: begin
               // Input bits are not stored during dummy clocks
               if (sclk_rise) begin
                  bit_cnt <= bit_cnt + 5'h01; // [RULE21] [RULE23]
               end
               if (dummy_done) begin
                  state <= SFSR_DATA;
               end
            end
            SFSR_WRDATA: begin
               if (sclk_rise) begin
                  wr_data <= {wr_data[14:0], din_s};
                  if (wr_cnt != `SFSR_WR_SAT) begin
                     wr_cnt <= wr_cnt + 5'h01;
                  end
               end
            end
            SFSR_IGNORE: begin
               if (sclk_rise && bit_cnt != `SFSR_WR_SAT) begin
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
            default: begin
               if (byte_done) begin
                  addr <= addr + 24'h000001; // [RULE18]
               end
            end
         endcase
      end
   end

   // ============================================================
   // Output shifting
   wire [7:0] status_byte = (cmd == `SFSR_OP_STATUS_READ_HI) ? status_out[15:8] : status_out[7:0];
   wire [7:0] tx_src = (state == SFSR_DATA) ? mem_data_in : status_byte;
   wire shifting = (state == SFSR_DATA) | (state == SFSR_STATUS);

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_sh <= 8'h00;
         tx_cnt <= 3'h0;
         data_line_0_out <= 1'b0;
         data_line_1_out <= 1'b0;
      end else if (state == SFSR_INT) begin
         data_line_1_out <= write_in_progress_flag; // [RULE8] [RULE9]
      end else if (!shifting) begin
         tx_cnt <= 3'h0;
      end else if (sclk_fall) begin
         tx_cnt <= (tx_cnt == tx_last) ? 3'h0 : tx_cnt + 3'h1;
         if (is_dual && state == SFSR_DATA) begin
            // Line 1 odd bit, line 0 even bit, top pair first
            {data_line_1_out, data_line_0_out} <= (tx_cnt == 3'h0) ? tx_src[7:6] : tx_sh[7:6]; // [RULE22] [RULE24]
            tx_sh <= (tx_cnt == 3'h0) ? {tx_src[5:0], 2'b00} : {tx_sh[5:0], 2'b00};
         end else begin
            // Fresh byte each group of eight keeps status current
            data_line_1_out <= (tx_cnt == 3'h0) ? tx_src[7] : tx_sh[7]; // [RULE4] [RULE6]
            tx_sh <= (tx_cnt == 3'h0) ? {tx_src[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_line_1_oe_out <= 1'b0;
         data_line_0_oe_out <= 1'b0;
      end else begin
         data_line_1_oe_out <= selected & (shifting | state == SFSR_INT); // [RULE10]
         // Line 0 turns round only at the first data fall, after the host let go
         data_line_0_oe_out <= selected & is_dual & (state == SFSR_DATA) &
                               (sclk_fall | data_line_0_oe_out); // [RULE22]
      end
   end

   // ============================================================
   // Status word, write enable latch and timed write cycle
   wire hw_protect = vol_bits[`SFSR_BIT_STATUS_PROTECT_HIGH] | (vol_bits[`SFSR_BIT_STATUS_PROTECT_LOW] & ~wpn_s);
   wire plain_end = cs_rise & (state == SFSR_IGNORE) & (bit_cnt == 5'h00) & ~write_in_progress_flag;
   wire end_write_enable_cmd = plain_end & (cmd == `SFSR_OP_WRITE_ENABLE);
   wire end_vol = plain_end & (cmd == `SFSR_OP_VOL_ENABLE);
   wire end_wr = cs_rise & (state == SFSR_WRDATA) & (wr_cnt == 5'h08 || wr_cnt == 5'h10);
   wire go_wr = end_wr & (write_enable_latch | vol_arm) & ~hw_protect & ~write_in_progress_flag;
   wire [15:0] cur_word = {vol_bits, write_enable_latch, write_in_progress_flag};
   wire [15:0] wr_val = (wr_cnt == 5'h08) ? {cur_word[15:8], wr_data[7:0]} : {wr_data[7:0], wr_data[15:8]};
   wire [15:0] new_word = (cur_word & `SFSR_KEEP_MASK) | (wr_val & ~`SFSR_KEEP_MASK);
   wire cycle_end = cycle_busy & (timer == 32'h0);

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         loaded <= 1'b0;
         vol_bits <= 14'(`SFSR_STATUS_RESET >> 2);
         write_enable_latch <= 1'b0;
         vol_arm <= 1'b0;
      end else begin
         if (!loaded) begin
            loaded <= 1'b1;
            vol_bits <= nv_status_in[15:2]; // [RULE3]
         end else if (go_wr) begin
            vol_bits <= new_word[15:2]; // [RULE11] [RULE13] [RULE14] [RULE16]
         end
         if (end_write_enable_cmd) begin
            write_enable_latch <= 1'b1; // [RULE12]
         end else if (cycle_end) begin
            write_enable_latch <= 1'b0; // [RULE15]
         end
         // Arming lasts for exactly the next command
         if (end_vol) begin
            vol_arm <= 1'b1; // [RULE1] [RULE2]
         end else if (cs_rise && state != SFSR_IDLE) begin
            vol_arm <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cycle_busy <= 1'b0;
         timer <= 32'h0;
         nv_write_out <= 1'b0;
         nv_data_out <= 16'h0000;
      end else begin
         nv_write_out <= cycle_end;
         if (go_wr && !vol_arm) begin
            cycle_busy <= 1'b1; // [RULE15]
            timer <= 32'(TW_CYCLES - 1);
            nv_data_out <= new_word;
         end else if (cycle_end) begin
            cycle_busy <= 1'b0;
         end else if (cycle_busy) begin
            timer <= timer - 32'h1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         write_in_progress_flag <= 1'b0;
         status_out <= `SFSR_STATUS_RESET;
         mem_addr_out <= 24'h000000;
      end else begin
         write_in_progress_flag <= cycle_busy | array_busy_in;
         status_out <= cur_word;
         mem_addr_out <= (state == SFSR_ADDR) ? {addr[22:0], din_s} : addr;
      end
   end

   // ============================================================
   // Checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   write_enable_cmd_sets_wel_a: assert property (end_write_enable_cmd |=> write_enable_latch) // [RULE12]
      else $error("write enable did not set the latch");
   vol_keeps_wel_a: assert property (end_vol |=> (write_enable_latch == $past(write_enable_latch)) && vol_arm) // [RULE2]
      else $error("volatile enable disturbed the latch");
   keep_bits_a: assert property (go_wr |=> vol_bits[15] == $past(vol_bits[15]) && // [RULE13]
      vol_bits[10] == $past(vol_bits[10]))
      else $error("status write changed a fixed bit");
   bad_count_a: assert property (cs_rise && state == SFSR_WRDATA && !end_wr && !cycle_busy // [RULE14]
      |=> !cycle_busy && vol_bits == $past(vol_bits))
      else $error("status write ran at a wrong bit count");
   cycle_busy_a: assert property (go_wr && !vol_arm |=> cycle_busy [*2] ##1 write_in_progress_flag) // [RULE15]
      else $error("write in progress not raised for timed write");
   cycle_clear_a: assert property ($fell(cycle_busy) |-> !write_enable_latch) // [RULE15]
      else $error("latch not cleared at end of write cycle");
   int_no_rise_a: assert property (state == SFSR_INT && $past(state) == SFSR_INT && // [RULE9]
      !data_line_1_out && !write_in_progress_flag && !cycle_busy && !array_busy_in |=> !data_line_1_out || state != SFSR_INT)
      else $error("interrupt status output rose");
   cs_float_a: assert property (!selected |=> !data_line_1_oe_out && !data_line_0_oe_out) // [RULE10]
      else $error("output driven while deselected");
   read_busy_a: assert property (op_done && is_read && write_in_progress_flag |=> state == SFSR_IGNORE) // [RULE20]
      else $error("array read accepted while busy");
   addr_step_a: assert property (byte_done && selected |=> addr == $past(addr) + 24'h000001) // [RULE18]
      else $error("read address did not advance");
endmodule : sfsr_core

/* File: tb/sfsr_host_model.sv */
// Host-side SPI controller model driving chip select, serial clock and the data input line
`timescale 1ns/1ps
module sfsr_host_model (
   input wire logic core_clk_in,
   output logic spi_csn_out,
   output logic spi_sclk_out,
   output logic mosi_out,
   output logic mosi_oe_out,
   input wire logic line0_in,
   input wire logic line1_in
);
   // ============================================================
   // Frame tasks: pins change only by non-blocking assignment on the core clock edge
   initial begin
      spi_csn_out = 1'b1;
      spi_sclk_out = 1'b0;
      mosi_out = 1'b0;
      mosi_oe_out = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : wait_clk

   task automatic select();
      spi_csn_out <= 1'b0;
      mosi_oe_out <= 1'b1;
      wait_clk(4);
   endtask : select

   // Clock parks low before the rise, so the last bit is never clipped
   task automatic deselect();
      spi_sclk_out <= 1'b0;
      wait_clk(4);
      spi_csn_out <= 1'b1;
      mosi_oe_out <= 1'b0;
      wait_clk(8);
   endtask : deselect

   task automatic release_line0();
      mosi_oe_out <= 1'b0;
      wait_clk(1);
   endtask : release_line0

   // Mode 0, 160 ns period; both lines sampled late in the high phase, where output has settled
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx1, output logic [31:0] rx0);
      rx1 = '0;
      rx0 = '0;
      for (int i = n - 1; i >= 0; i--) begin
         spi_sclk_out <= 1'b0;
         mosi_out <= tx[i];
         wait_clk(4);
         spi_sclk_out <= 1'b1;
         wait_clk(4);
         rx1[i] = line1_in;
         rx0[i] = line0_in;
      end
   endtask : xfer
endmodule : sfsr_host_model

/* File: tb/testbench.sv */
// Self-checking bench for the serial flash status and read command engine
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module testbench;
   logic core_clk_in, resetn_in, wp_n_in, array_busy_in, toggle;
   logic csn, sclk, mosi, mosi_oe, line0, line1, d0_out, d0_oe, d1_out, d1_oe, nv_write_out;
   logic [15:0] nv_status_in, status_out, nv_data_out, nv_last, two;
   logic [23:0] mem_addr_out;
   logic [7:0] mem_data_in;
   logic [31:0] rx1, rx0;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int nv_pulses = 0;
   int oe1_cycles = 0;

   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'h5A;
   endfunction : mem_byte

   // ============================================================
   // Wires and instances; an undriven line wanders so a stale bit never passes for data
   assign line0 = d0_oe ? d0_out : (mosi_oe ? mosi : toggle);
   assign line1 = d1_oe ? d1_out : toggle;
   assign mem_data_in = mem_byte(mem_addr_out);

   sfsr_core #(.TW_CYCLES(2000)) sfsr_core_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .spi_csn_in(csn), .spi_sclk_in(sclk), .wp_n_in(wp_n_in), .data_line_0_in(line0),
      .data_line_0_out(d0_out), .data_line_0_oe_out(d0_oe), .data_line_1_in(line1), .data_line_1_out(d1_out),
      .data_line_1_oe_out(d1_oe), .nv_status_in(nv_status_in), .array_busy_in(array_busy_in),
      .mem_data_in(mem_data_in), .mem_addr_out(mem_addr_out), .status_out(status_out),
      .nv_write_out(nv_write_out), .nv_data_out(nv_data_out));
   sfsr_host_model sfsr_host_model_inst (.core_clk_in(core_clk_in), .spi_csn_out(csn), .spi_sclk_out(sclk),
      .mosi_out(mosi), .mosi_oe_out(mosi_oe), .line0_in(line0), .line1_in(line1));

   initial begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in) begin
      toggle <= ~toggle;
      cycles <= cycles + 1;
      if (d1_oe === 1'b1) oe1_cycles <= oe1_cycles + 1;
      if (nv_write_out === 1'b1) begin
         nv_pulses <= nv_pulses + 1;
         nv_last <= nv_data_out;
      end
      if (cycles == 60000) begin
         failures = failures + 1;
         stop_test();
      end
   end

   // ============================================================
   // Command helpers
   task automatic wclk(input int n);
      sfsr_host_model_inst.wait_clk(n);
   endtask : wclk

   task automatic shift(input int n, input logic [31:0] tx);
      sfsr_host_model_inst.xfer(n, tx, rx1, rx0);
   endtask : shift

   task automatic cmd(input logic [7:0] op);
      sfsr_host_model_inst.select();
      shift(8, {24'h000000, op});
      sfsr_host_model_inst.deselect();
   endtask : cmd

   task automatic status_write_cmd(input int n, input logic [15:0] d);
      sfsr_host_model_inst.select();
      shift(8, 32'h00000001);
      shift(n, {16'h0000, d});
      sfsr_host_model_inst.deselect();
   endtask : status_write_cmd

   // Two bytes in one frame, so the repeat of the byte is seen as well
   task automatic status_rd(input logic [7:0] op);
      sfsr_host_model_inst.select();
      shift(8, {24'h000000, op});
      shift(16, 32'h00000000);
      two = rx1[15:0];
      sfsr_host_model_inst.deselect();
   endtask : status_rd

   // ============================================================
   // Scenarios
   task automatic t_power_up();
      `CHK("status after reset", 16'h1234, status_out)
      status_rd(8'h05);
      `CHK("low status byte twice", 16'h3434, two)
      status_rd(8'h35);
      `CHK("high status byte twice", 16'h1212, two)
   endtask : t_power_up

   task automatic t_status_write();
      int k;
      int oe_before;
      status_write_cmd(16, 16'h7FFE);
      `CHK("write without enable", 16'h1234, status_out)
      cmd(8'h06);
      `CHK("enable latch", 1'b1, status_out[1])
      status_write_cmd(16, 16'h7FFE);
      `CHK("status during cycle", 16'h7A7F, status_out)
      status_rd(8'h05);
      `CHK("status read while busy", 16'h7F7F, two)
      oe_before = oe1_cycles;
      sfsr_host_model_inst.select();
      shift(8, 32'h00000003);
      shift(24, 32'h00000000);
      shift(8, 32'h00000000);
      sfsr_host_model_inst.deselect();
      `CHK("read refused while busy", oe_before, oe1_cycles)
      sfsr_host_model_inst.select();
      shift(8, 32'h00000025);
      wclk(6);
      `CHK("busy level", 2'b11, {d1_oe, d1_out})
      for (k = 0; k < 3000 && d1_out !== 1'b0; k++) wclk(1);
      `CHK("level falls at completion", 1'b1, k < 3000)
      wclk(4);
      `CHK("status after cycle", 16'h7A7C, status_out)
      `CHK("commit pulses", 1, nv_pulses)
      `CHK("committed word", 16'h7A7C, nv_last & 16'h7BFC)
      sfsr_host_model_inst.deselect();
      `CHK("output floats after deselect", 1'b0, d1_oe)
   endtask : t_status_write

   task automatic t_volatile_and_count();
      cmd(8'h50);
      status_write_cmd(8, 16'h0000);
      `CHK("volatile write", 16'h7A00, status_out)
      `CHK("no commit for volatile", 1, nv_pulses)
      cmd(8'h06);
      status_write_cmd(12, 16'h0FFF);
      wclk(4);
      `CHK("twelve bits refused", 16'h7A00, status_out & 16'hFFFD)
   endtask : t_volatile_and_count

   task automatic t_array_reads();
      logic [7:0] b0;
      logic [7:0] b1;
      sfsr_host_model_inst.select();
      shift(32, 32'h03FFFFFF);
      shift(16, 32'h00000000);
      `CHK("read top byte", mem_byte(24'hFFFFFF), rx1[15:8])
      `CHK("read wraps to zero", mem_byte(24'h000000), rx1[7:0])
      shift(4, 32'h00000000);
      sfsr_host_model_inst.deselect();
      `CHK("mid byte abort", 1'b0, d1_oe)
      sfsr_host_model_inst.select();
      shift(32, 32'h0B000010);
      shift(16, 32'h0000FF00);
      `CHK("fast read after dummy", mem_byte(24'h000010), rx1[7:0])
      sfsr_host_model_inst.deselect();
      sfsr_host_model_inst.select();
      shift(32, 32'h3B00ABCD);
      shift(8, 32'h000000A5);
      sfsr_host_model_inst.release_line0();
      shift(8, 32'h00000000);
      for (int k = 0; k < 4; k++) begin
         b0[7 - 2 * k] = rx1[7 - k];
         b0[6 - 2 * k] = rx0[7 - k];
         b1[7 - 2 * k] = rx1[3 - k];
         b1[6 - 2 * k] = rx0[3 - k];
      end
      sfsr_host_model_inst.deselect();
      `CHK("dual byte one", mem_byte(24'h00ABCD), b0)
      `CHK("dual byte two", mem_byte(24'h00ABCE), b1)
   endtask : t_array_reads

   task automatic t_hw_protect();
      cmd(8'h50);
      status_write_cmd(8, 16'h0080);
      `CHK("protect bit set", 16'h7A80, status_out & 16'hFFFD)
      wp_n_in <= 1'b0;
      wclk(6);
      cmd(8'h06);
      status_write_cmd(8, 16'h0000);
      wclk(4);
      `CHK("write under protection", 16'h7A80, status_out & 16'hFFFD)
      `CHK("no cycle started", 1'b0, status_out[0])
   endtask : t_hw_protect

   // Program/erase busy from the array side must block reads exactly as a timed write does
   task automatic t_array_busy();
      int oe_before;
      array_busy_in <= 1'b1;
      wclk(4);
      oe_before = oe1_cycles;
      sfsr_host_model_inst.select();
      shift(32, 32'h0B000010);
      shift(16, 32'h00000000);
      sfsr_host_model_inst.deselect();
      `CHK("fast read refused while busy", oe_before, oe1_cycles)
      status_rd(8'h05);
      `CHK("array busy seen in status", 2'b11, {two[8], two[0]})
      array_busy_in <= 1'b0;
      wclk(4);
   endtask : t_array_busy

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      resetn_in = 1'b0;
      wp_n_in = 1'b1;
      array_busy_in = 1'b0;
      toggle = 1'b0;
      nv_status_in = 16'h1234;
      repeat (6) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      t_power_up();
      t_status_write();
      t_volatile_and_count();
      t_array_reads();
      t_hw_protect();
      t_array_busy();
      stop_test();
   end
endmodule : testbench
